// *** dv/calbo_core_monitor.sv ***
`timescale 1ns/1ps
module calbo_core_monitor
#(
   parameter logic [6:0] PORT_ADDR = calbo_pkg::PORT_ADDR_DEF
)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire calbo_pkg::calbo_instr_t i_instr,
   input wire logic [7:0] i_port_pins,
   input wire logic [7:0] o_port_latch,
   input wire logic [7:0] o_acc,
   input wire calbo_pkg::calbo_flags_t o_flags,
   input wire logic o_skip_pending,
   input wire logic o_done,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic [8:0] op;
   ////////////////////////////////////////////////////////////////////////////
   // Op that really executes; a discarded slot reads as zero
   assign op = (i_instr_valid && !o_skip_pending) ? i_instr.op : 9'h000;
   chk_done_pulse:
   assert property (op != 9'h000 && op != calbo_pkg::OP_TEST_SKIP |=> o_done) else $error("done missing");
   chk_skip_slot:
   assert property (o_skip_pending && i_instr_valid |=> o_done && !o_skip_pending && $stable(o_acc)
      && $stable(o_flags)) else $error("skipped slot not discarded");
   chk_skip_quiet:
   assert property (op == calbo_pkg::OP_TEST_SKIP |=> (o_done != o_skip_pending) && $stable(o_flags) && $stable(o_acc))
      else $error("test changed state");
   chk_add_lit:
   assert property (op == calbo_pkg::OP_ADD_LIT |=> o_acc == $past(o_acc) + $past(i_instr.literal)
      && o_flags.c == (9'($past(o_acc)) + 9'($past(i_instr.literal)) > 9'h0ff)) else $error("add literal wrong");
   chk_and_lit:
   assert property (op == calbo_pkg::OP_AND_LIT |=> o_acc == ($past(o_acc) & $past(i_instr.literal))
      && o_flags.z == (o_acc == 8'h00) && $stable(o_flags.c) && $stable(o_flags.dc)) else $error("and literal wrong");
   chk_bit_flags:
   assert property (op == calbo_pkg::OP_CLR_BIT || op == calbo_pkg::OP_SET_BIT |=> $stable(o_flags)
      && $stable(o_acc)) else $error("bit op touched acc or flags");
   chk_clr_reg:
   assert property (op == calbo_pkg::OP_CLR_REG |=> o_flags.z && $stable(o_flags.c) && $stable(o_flags.dc))
      else $error("clear register flags wrong");
   chk_and_dest:
   assert property (op == calbo_pkg::OP_AND_REG && i_instr.dest |=> $stable(o_acc) && $stable(o_flags.c))
      else $error("and to file changed acc or carry");
   chk_port_pins:
   assert property (op == calbo_pkg::OP_SET_BIT && i_instr.addr == PORT_ADDR |=> o_port_latch ==
      ($past(i_port_pins) | (8'h01 << $past(i_instr.bit_sel)))) else $error("port operand not from pins");
   chk_apb_ready:
   assert property (i_psel && !i_penable |=> o_pready) else $error("pready late");
   // Main scenarios
   cov_skip: cover property (op == calbo_pkg::OP_TEST_SKIP ##1 o_skip_pending);
   cov_back: cover property (op != 9'h000 ##1 op != 9'h000);
   cov_port: cover property (op == calbo_pkg::OP_CLR_BIT && i_instr.addr == PORT_ADDR);
endmodule
bind calbo_core calbo_core_monitor #(.PORT_ADDR(PORT_ADDR)) calbo_core_monitor_i (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_port_pins(i_port_pins), .o_port_latch(o_port_latch),
   .o_acc(o_acc), .o_flags(o_flags), .o_skip_pending(o_skip_pending), .o_done(o_done), .i_psel(i_psel),
   .i_penable(i_penable), .o_pready(o_pready));

// *** dv/tb_calbo_core.sv ***
`timescale 1ns/1ps
module tb_calbo_core;
   localparam logic [6:0] PADR = 7'h06;
   logic i_mclk = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0;
   calbo_pkg::calbo_instr_t i_instr = '0;
   logic [7:0] i_port_pins = 8'h00;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic [31:0] o_prdata, rd;
   logic [7:0] o_port_latch, o_acc, m_acc;
   logic [7:0] m_file [128];
   calbo_pkg::calbo_flags_t o_flags;
   logic [2:0] m_flg;
   logic o_skip_pending, o_done, o_pready, o_pslverr, m_skip, err;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   logic [7:0] exp_acc, exp_latch;
   logic [2:0] exp_flg;
   logic exp_skip, exp_done;
   int exp_seq = 0, seen_seq = 0;
   calbo_core #(.PORT_ADDR(PADR)) calbo_core_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .i_port_pins(i_port_pins), .o_port_latch(o_port_latch), .o_acc(o_acc), .o_flags(o_flags),
      .o_skip_pending(o_skip_pending), .o_done(o_done), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and a hang guard well above the planned run length
   always #50 i_mclk = ~i_mclk;
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         fail("timeout");
         test_done();
      end
   end
   task automatic fail(input string m);
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // APB transfer; leading idle edge keeps release and next setup apart, and
   // the instruction stream is paused so a held instruction is not run twice
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      i_instr_valid <= 1'b0;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= {24'h00_0000, d};
      @(posedge i_mclk);
      i_penable <= 1'b1;
      @(posedge i_mclk);
      while (o_pready !== 1'b1)
      begin
         @(posedge i_mclk);
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      num_checks++;
      if (rd !== {24'h00_0000, e} || err !== 1'b0) fail("read data");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // One instruction; the model works out acc, flags, file and skip
   task automatic exec(input logic [8:0] op, input logic [6:0] a, input logic d, input logic [2:0] b,
      input logic [7:0] k);
      logic [8:0] s;
      logic [7:0] f, r, p;
      logic sk;
      p = 8'($urandom);
      i_instr <= '{calbo_pkg::calbo_op_t'(op), a, d, b, k};
      i_instr_valid <= 1'b1;
      i_port_pins <= p;
      sk = m_skip;
      m_skip = 1'b0;
      f = (a == PADR) ? p : m_file[a];
      r = (op[1] | op[4]) ? k : f;
      s = {1'b0, m_acc} + {1'b0, r};
      if (!sk && (op[1] | op[2]))
         m_flg = {s[7:0] == 8'h00, {1'b0, m_acc[3:0]} + {1'b0, r[3:0]} > 5'h0f, s[8]};
      if (!sk && (op[3] | op[4]))
         m_flg[2] = (m_acc & r) == 8'h00;
      if (!sk && op[8])
         m_flg[2] = 1'b1;
      if (!sk && op[7])
         m_skip = f[b];
      r = (op[1] | op[2]) ? s[7:0] : (op[3] | op[4]) ? (m_acc & r) : op[8] ? 8'h00 : f;
      r[b] = op[5] ? 1'b0 : op[6] ? 1'b1 : r[b];
      if (!sk && (op[1] | op[4] | ((op[2] | op[3]) && !d)))
         m_acc = r;
      if (!sk && (op[5] | op[6] | op[8] | ((op[2] | op[3]) && d)))
         m_file[a] = r;
      // Taken at this edge; the falling-edge check compares after it
      @(posedge i_mclk);
      exp_acc = m_acc;
      exp_flg = m_flg;
      exp_latch = m_file[PADR];
      exp_skip = m_skip;
      exp_done = !m_skip; // Only a taken skip retires without a pulse
      exp_seq++;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Results compared at the falling edge, clear of the edge that launches them
   always @(negedge i_mclk)
   begin
      if (exp_seq != seen_seq)
      begin
         seen_seq = exp_seq;
         num_checks += 5;
         if (o_acc !== exp_acc) fail("acc");
         if (o_flags !== exp_flg) fail("flags");
         if (o_port_latch !== exp_latch) fail("port latch");
         if (o_skip_pending !== exp_skip) fail("skip");
         if (o_done !== exp_done) fail("done");
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rd = $urandom(54609);
      m_acc = 8'h00;
      m_flg = 3'h0;
      m_skip = 1'b0;
      repeat (20) @(posedge i_mclk);
      i_rst <= 1'b0;
      for (int i = 0; i < 128; i++)
      begin
         m_file[i] = 8'($urandom);
         apb(1'b1, 12'h200 + 12'(i * 4), m_file[i]);
      end
      // Wrap to zero sets every flag
      apb(1'b1, 12'h000, 8'hff);
      m_acc = 8'hff;
      exec(9'h002, 7'h00, 1'b1, 3'h0, 8'h01);
      // Skip on bit 7, then the discarded slot
      exec(9'h040, 7'h7f, 1'b0, 3'h7, 8'h00);
      exec(9'h080, 7'h7f, 1'b0, 3'h7, 8'h00);
      exec(9'h100, 7'h7f, 1'b0, 3'h0, 8'h00);
      apb(1'b1, 12'h00c, 8'h5a);
      num_checks++;
      if (err !== 1'b1) fail("unmapped accepted");
      rdchk(12'h008, i_port_pins);
      // Random stream, mostly back to back, port register often
      for (int i = 0; i < 500; i++)
      begin
         exec(9'h001 << ($urandom % 9), ($urandom % 4 == 0) ? PADR : 7'($urandom), 1'($urandom), 3'($urandom),
            8'($urandom));
         if ($urandom % 6 == 0)
         begin
            i_instr_valid <= 1'b0;
            @(posedge i_mclk);
         end
      end
      rdchk(12'h000, m_acc);
      rdchk(12'h004, {5'h00, m_flg});
      for (int i = 0; i < 128; i++)
         rdchk(12'h200 + 12'(i * 4), (i == PADR) ? i_port_pins : m_file[i]);
      test_done();
   end
endmodule

// *** hw/calbo_alu.sv ***
`timescale 1ns/1ps
module calbo_alu
(
   input wire calbo_pkg::calbo_instr_t i_instr,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_file,
   output calbo_pkg::calbo_alu_out_t o_out
);

   logic [7:0] operand;
   logic [8:0] sum;
   logic [4:0] half_sum;
   logic [7:0] bit_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Operand select and adder; literal forms take the immediate
   always_comb
   begin
      if (i_instr.op == calbo_pkg::OP_ADD_LIT || i_instr.op == calbo_pkg::OP_AND_LIT)
      begin
         operand = i_instr.literal;
      end
      else
      begin
         operand = i_file;
      end
      sum = {1'b0, i_acc} + {1'b0, operand};
      half_sum = {1'b0, i_acc[3:0]} + {1'b0, operand[3:0]};
      bit_mask = 8'h01 << i_instr.bit_sel;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-operation result, flag enables and destination
   always_comb
   begin
      o_out = '0;
      case (i_instr.op)
         calbo_pkg::OP_ADD_LIT:
         begin
            o_out.result = sum[7:0];
            o_out.flags.c = sum[8];
            o_out.flags.dc = half_sum[4];
            o_out.flags.z = (sum[7:0] == 8'h00);
            o_out.flag_we = 3'h7;
            o_out.wr_acc = 1'b1;
         end
         calbo_pkg::OP_ADD_REG:
         begin
            o_out.result = sum[7:0];
            o_out.flags.c = sum[8];
            o_out.flags.dc = half_sum[4];
            o_out.flags.z = (sum[7:0] == 8'h00);
            o_out.flag_we = 3'h7;
            o_out.wr_acc = ~i_instr.dest;
            o_out.wr_file = i_instr.dest;
         end
         calbo_pkg::OP_AND_REG:
         begin
            o_out.result = i_acc & operand;
            o_out.flags.z = ((i_acc & operand) == 8'h00);
            o_out.flag_we.z = 1'b1;
            o_out.wr_acc = ~i_instr.dest;
            o_out.wr_file = i_instr.dest;
         end
         calbo_pkg::OP_AND_LIT:
         begin
            o_out.result = i_acc & operand;
            o_out.flags.z = ((i_acc & operand) == 8'h00);
            o_out.flag_we.z = 1'b1;
            o_out.wr_acc = 1'b1;
         end
         calbo_pkg::OP_CLR_BIT:
         begin
            o_out.result = i_file & ~bit_mask;
            o_out.wr_file = 1'b1;
         end
         calbo_pkg::OP_SET_BIT:
         begin
            o_out.result = i_file | bit_mask;
            o_out.wr_file = 1'b1;
         end
         calbo_pkg::OP_TEST_SKIP:
         begin
            o_out.skip = i_file[i_instr.bit_sel];
         end
         calbo_pkg::OP_CLR_REG:
         begin
            o_out.result = 8'h00;
            o_out.flags.z = 1'b1;
            o_out.flag_we.z = 1'b1;
            o_out.wr_file = 1'b1;
         end
         default:
         begin
            o_out = '0;
         end
      endcase
   end

endmodule

// *** hw/calbo_core.sv ***
// How it works
// - Add-literal adds the eight-bit immediate to the accumulator, stores the sum there and updates C, DC and Z.
// - Add-to-register adds the accumulator to one of 128 file registers and updates C, DC and Z from the sum.
// - For register-operand arithmetic and logic, destination 0 writes the accumulator and 1 the file register.
// - And-with-register ANDs accumulator and file register into the chosen destination and updates only Z.
// - And-literal ANDs the accumulator with the immediate, stores it in the accumulator and updates only Z.
// - Clear-bit forces the indexed bit of the file register to zero and touches nothing else.
// - Set-bit forces the indexed bit of the file register to one and touches nothing else.
// - Test-and-skip discards the next instruction when the tested bit is one, taking two cycles, flags untouched.
// - Clear-register writes zero into the file register and sets Z, leaving other flags alone.
// - Reading the port register takes the live pin levels rather than the output latch.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module calbo_core
#(
   parameter logic [6:0] PORT_ADDR = calbo_pkg::PORT_ADDR_DEF
)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   // Decoded instruction stream, one per cycle while valid
   input wire logic i_instr_valid,
   input wire calbo_pkg::calbo_instr_t i_instr,
   // Port pins and output latch
   input wire logic [7:0] i_port_pins,
   output logic [7:0] o_port_latch,
   // Core state seen by the sequencer
   output logic [7:0] o_acc,
   output calbo_pkg::calbo_flags_t o_flags,
   output logic o_skip_pending,
   output logic o_done,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);

   ////////////////////////////////////////////////////////////////////////////
   // All module state in one struct
   typedef struct packed
   {
      calbo_pkg::calbo_state_t state;
      logic [7:0] acc;
      calbo_pkg::calbo_flags_t flags;
      logic [127:0][7:0] file;
      logic done;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } calbo_regs_t;

   calbo_regs_t st;
   calbo_regs_t next_st;
   calbo_pkg::calbo_alu_out_t alu_out;
   logic [7:0] file_operand;
   logic apb_setup;
   logic apb_commit;
   logic hit_acc;
   logic hit_status;
   logic hit_pins;
   logic hit_file;
   logic [6:0] apb_index;
   logic [7:0] apb_file_val;
   logic exec;

   ////////////////////////////////////////////////////////////////////////////
   // Operand fetch; the port address reads pins so a read-modify-write
   // reflects what the outside drives, not what the latch holds
   always_comb
   begin
      if (i_instr.addr == PORT_ADDR)
      begin
         file_operand = i_port_pins;
      end
      else
      begin
         file_operand = st.file[i_instr.addr];
      end
   end

   calbo_alu u_alu
   (
      .i_instr(i_instr),
      .i_acc(st.acc),
      .i_file(file_operand),
      .o_out(alu_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   always_comb
   begin
      apb_setup = i_psel & ~i_penable;
      apb_commit = i_psel & i_penable & st.pready;
      hit_acc = (i_paddr == calbo_pkg::REG_ACC);
      hit_status = (i_paddr == calbo_pkg::REG_STATUS);
      hit_pins = (i_paddr == calbo_pkg::REG_PINS);
      hit_file = (i_paddr[11:9] == calbo_pkg::FILE_REGION) && (i_paddr[1:0] == 2'h0);
      apb_index = i_paddr[8:2];
      // Software sees the same pin view as the instructions do
      if (apb_index == PORT_ADDR)
      begin
         apb_file_val = i_port_pins;
      end
      else
      begin
         apb_file_val = st.file[apb_index];
      end
   end

   // An instruction in the shadow of a taken skip is consumed, not run
   assign exec = i_instr_valid && (st.state == calbo_pkg::ST_EXEC);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;

      // APB: ready comes one cycle after setup, so every transfer is two cycles
      next_st.pready = apb_setup;
      if (apb_setup)
      begin
         next_st.pslverr = ~(hit_acc | hit_status | hit_pins | hit_file);
         next_st.prdata = 32'h0000_0000;
         if (hit_acc)
         begin
            next_st.prdata[7:0] = st.acc;
         end
         else if (hit_status)
         begin
            next_st.prdata[2:0] = st.flags;
         end
         else if (hit_pins)
         begin
            next_st.prdata[7:0] = i_port_pins;
         end
         else if (hit_file)
         begin
            next_st.prdata[7:0] = apb_file_val;
         end
      end
      else
      begin
         // Error lives only beside ready, so the output needs no gating
         next_st.pslverr = 1'b0;
      end

      // Software writes land first; an instruction in the same cycle overrides
      if (apb_commit && i_pwrite)
      begin
         if (hit_acc)
         begin
            next_st.acc = i_pwdata[7:0];
         end
         else if (hit_status)
         begin
            next_st.flags = i_pwdata[2:0];
         end
         else if (hit_file)
         begin
            next_st.file[apb_index] = i_pwdata[7:0];
         end
      end

      // Instruction execution, single cycle
      case (st.state)
         calbo_pkg::ST_EXEC:
         begin
            if (exec)
            begin
               if (alu_out.wr_acc)
               begin
                  next_st.acc = alu_out.result;
               end
               if (alu_out.wr_file)
               begin
                  next_st.file[i_instr.addr] = alu_out.result;
               end
               if (alu_out.flag_we.c)
               begin
                  next_st.flags.c = alu_out.flags.c;
               end
               if (alu_out.flag_we.dc)
               begin
                  next_st.flags.dc = alu_out.flags.dc;
               end
               if (alu_out.flag_we.z)
               begin
                  next_st.flags.z = alu_out.flags.z;
               end
               if (alu_out.skip)
               begin
                  next_st.state = calbo_pkg::ST_SKIP;
               end
               else
               begin
                  next_st.done = 1'b1;
               end
            end
         end
         calbo_pkg::ST_SKIP:
         begin
            // Second cycle runs as a no-op on whatever arrives
            if (i_instr_valid)
            begin
               next_st.state = calbo_pkg::ST_EXEC;
               next_st.done = 1'b1;
            end
         end
         default:
         begin
            next_st.state = calbo_pkg::ST_EXEC;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st.state <= calbo_pkg::ST_EXEC;
         st.acc <= calbo_pkg::ACC_RST;
         st.flags <= calbo_pkg::STATUS_RST;
         st.file <= {calbo_pkg::FILE_DEPTH{calbo_pkg::FILE_RST}};
         st.done <= 1'b0;
         st.pready <= 1'b0;
         st.prdata <= 32'h0000_0000;
         st.pslverr <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state flops
   assign o_acc = st.acc;
   assign o_flags = st.flags;
   assign o_port_latch = st.file[PORT_ADDR];
   assign o_skip_pending = st.state[1]; // One-hot, bit 1 is the skip state
   assign o_done = st.done;
   assign o_prdata = st.prdata;
   assign o_pready = st.pready;
   assign o_pslverr = st.pslverr;

endmodule

// *** include/calbo_pkg.sv ***
package calbo_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Datapath sizes
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int FILE_DEPTH = 128;
   localparam int APB_AW = 12;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the APB side
   localparam logic [11:0] REG_ACC = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_PINS = 12'h008;
   // File registers, one word each, index in paddr[8:2]
   localparam logic [2:0] FILE_REGION = 3'h1;

   // Status field positions
   localparam int STAT_C = 0;
   localparam int STAT_DC = 1;
   localparam int STAT_Z = 2;

   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [2:0] STATUS_RST = 3'h0;
   localparam logic [7:0] FILE_RST = 8'h00;
   // File address that reads back from the port pins
   localparam logic [6:0] PORT_ADDR_DEF = 7'h06;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded operations, one-hot
   typedef enum logic [8:0]
   {
      OP_NOP = 9'h001,
      OP_ADD_LIT = 9'h002,
      OP_ADD_REG = 9'h004,
      OP_AND_REG = 9'h008,
      OP_AND_LIT = 9'h010,
      OP_CLR_BIT = 9'h020,
      OP_SET_BIT = 9'h040,
      OP_TEST_SKIP = 9'h080,
      OP_CLR_REG = 9'h100
   } calbo_op_t;

   // Sequencer state, one-hot
   typedef enum logic [1:0]
   {
      ST_EXEC = 2'h1,
      ST_SKIP = 2'h2
   } calbo_state_t;

   // Decoded instruction from the program sequencer
   typedef struct packed
   {
      calbo_op_t op;
      logic [6:0] addr;
      logic dest;
      logic [2:0] bit_sel;
      logic [7:0] literal;
   } calbo_instr_t;

   // Status flags, packed z:dc:c
   typedef struct packed
   {
      logic z;
      logic dc;
      logic c;
   } calbo_flags_t;

   // Result of one operation
   typedef struct packed
   {
      logic [7:0] result;
      calbo_flags_t flags;
      calbo_flags_t flag_we;
      logic wr_acc;
      logic wr_file;
      logic skip;
   } calbo_alu_out_t;

endpackage
